// [hw/bstap_pkg.sv]
/*
 * Package for the boundary-scan test access port controller: state codes,
 * instruction decode constants, register widths, reset values and the
 * structs that carry the sampled test pins and the data-register strobes.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
package bstap_pkg;

   // ---------------------------------------------------------------------
   // Widths and reset values
   // ---------------------------------------------------------------------
   localparam int unsigned IR_W      = 8;
   localparam int unsigned BCR_W     = 2;
   localparam int unsigned OPC_W     = 7;
   localparam int unsigned SYNC_N    = 3;
   localparam logic [7:0]  IR_RESET  = 8'hff;
   localparam logic [7:0]  IR_STATUS = 8'h81;
   localparam logic [1:0]  BCR_RESET = 2'h2;
   localparam logic        BYP_CAP   = 1'h0;
   localparam int unsigned FIFO_W    = 1;
   localparam int unsigned FIFO_D    = 16;

   // ---------------------------------------------------------------------
   // Opcodes (bit 7 ignored)
   // ---------------------------------------------------------------------
   localparam logic [6:0] OP_EXTEST = 7'h00;
   localparam logic [6:0] OP_SAMPLE = 7'h02;
   localparam logic [6:0] OP_INTEST = 7'h03;
   localparam logic [6:0] OP_HIGHZ  = 7'h06;
   localparam logic [6:0] OP_CLAMP  = 7'h07;
   localparam logic [6:0] OP_RUNT   = 7'h09;
   localparam logic [6:0] OP_READBN = 7'h0a;
   localparam logic [6:0] OP_READBT = 7'h0b;
   localparam logic [6:0] OP_CELLT  = 7'h0c;
   localparam logic [6:0] OP_TOPHIP = 7'h0d;
   localparam logic [6:0] OP_SCANCN = 7'h0e;
   localparam logic [6:0] OP_SCANCT = 7'h0f;

   // ---------------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_RESET  = 4'h0, ST_IDLE   = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
      ST_SH_DR  = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR  = 4'h6, ST_EX2_DR = 4'h7,
      ST_UP_DR  = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SH_IR  = 4'hb,
      ST_EX1_IR = 4'hc, ST_PA_IR  = 4'hd, ST_EX2_IR = 4'he, ST_UP_IR  = 4'hf
   } bstap_state_e;

   typedef enum logic [1:0] {
      DR_BYPASS = 2'h0, DR_BOUND = 2'h1, DR_BCTRL = 2'h2
   } bstap_dr_e;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } bstap_pins_s;

   typedef struct packed {
      logic capture;
      logic shift;
      logic update;
   } bstap_strobe_s;

endpackage : bstap_pkg

// [hw/bstap_tap.sv]
/*
 * Test access port controller with instruction register, boundary-control
 * and bypass registers, plus a parameterised FIFO for the serial-in stream.
 * Assumes the test clock, mode select and data input arrive asynchronously
 * on pins and are sampled by clk, which runs much faster than the test clock.
 * The boundary-scan cells themselves live outside; they see the strobes and
 * return their serial output on bsr_tdo.
 */
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Sixteen states, six stable, ten transient
// - Transitions follow mode select at test-clock rise
// - Power-up in reset state, test logic disabled
// - Mode select high reaches reset within five
// - Instruction forced all ones, selecting bypass
// - Boundary control reset to one-zero
// - Control-register tests run only in idle
// - Select states do nothing, leave next cycle
// - Capture connects one register, output enables falling
// - Output enables low after reset, else held
// - Data capture on edge leaving capture
// - Shift on each rise, not entering edge
// - Exit states end scan, no recapture
// - Pause holds shift contents unchanged
// - Data update on falling edge, output floats
// - Instruction capture loads one-six-zeros-one
// - Instruction latches update on falling edge
// - Eight-bit instruction, bit seven ignored
// - Unknown opcodes act as bypass, no parity
// - Shadow latches except on bypass register
// - Instruction picks mode, operation, register, source
// - Sample on rise, outputs change on fall
// - Bypass stage captures zero
// - Control register two bits, bypass one

// ------------------------------------------------------------------------
// Synchronous FIFO
// ------------------------------------------------------------------------
module bstap_fifo #(
   parameter int unsigned WIDTH = 1,
   parameter int unsigned DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp_r;
   logic [AW-1:0]    rp_r;
   logic [AW:0]      cnt_r;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem[rp_r];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wp_r <= wp_r + 1'b1;
         if (pop)  rp_r <= rp_r + 1'b1;
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : bstap_fifo

// ------------------------------------------------------------------------
// Controller top
// ------------------------------------------------------------------------
module bstap_tap (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // Test pins
   input  wire logic                 tck_pin,
   input  wire logic                 tms_pin,
   input  wire logic                 tdi_pin,
   output logic                      tdo_o,
   output logic                      tdo_oe,
   // Boundary-scan cell side
   input  wire logic                 bsr_tdo,
   output bstap_pkg::bstap_strobe_s  bsr_strobe,
   output logic                      bsr_sel,
   output logic                      bsr_tdi,
   // Decoded instruction
   output logic [6:0]                opcode,
   output logic                      test_mode,
   output logic                      highz_mode,
   output logic [1:0]                bctrl_op,
   output logic                      bctrl_run,
   output bstap_pkg::bstap_state_e   tap_state
);
   // ---------------------------------------------------------------------
   // Pin sampling, three stages; a change counts when 2nd and 3rd agree
   // ---------------------------------------------------------------------
   bstap_pkg::bstap_pins_s s1_r, s2_r, s3_r, pin_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_r  <= '1;
         s2_r  <= '1;
         s3_r  <= '1;
         pin_r <= '1;
      end else begin
         s1_r <= '{tck: tck_pin, tms: tms_pin, tdi: tdi_pin};
         s2_r <= s1_r;
         s3_r <= s2_r;
         pin_r <= (s2_r == s3_r) ? s3_r : pin_r;
      end
   end
   logic tck_d_r;
   always_ff @(posedge clk) begin
      if (rst) tck_d_r <= 1'b1;
      else     tck_d_r <= pin_r.tck;
   end
   wire tck_rise = pin_r.tck && !tck_d_r;
   wire tck_fall = !pin_r.tck && tck_d_r;

   // ---------------------------------------------------------------------
   // Serial input stream buffered; drained one bit per rising edge
   // ---------------------------------------------------------------------
   // Bits are pushed at each test-clock rise and popped one clk cycle later
   // by the shift logic, so the FIFO only absorbs skew, never data loss.
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire fifo_out_data;
   logic fifo_pop_r;
   bstap_fifo #(.WIDTH(bstap_pkg::FIFO_W), .DEPTH(bstap_pkg::FIFO_D)) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (tck_rise),
      .in_ready  (fifo_in_ready),
      .in_data   (pin_r.tdi),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop_r),
      .out_data  (fifo_out_data)
   );
   always_ff @(posedge clk) begin
      if (rst) fifo_pop_r <= 1'b0;
      else     fifo_pop_r <= tck_rise && fifo_in_ready;
   end
   wire step     = fifo_pop_r && fifo_out_valid;
   wire tdi_bit  = fifo_out_data;
   // Mode select captured with the same rise, aligned with the popped bit
   logic tms_s_r;
   always_ff @(posedge clk) begin
      if (rst)           tms_s_r <= 1'b1;
      else if (tck_rise) tms_s_r <= pin_r.tms;
   end

   // ---------------------------------------------------------------------
   // State machine
   // ---------------------------------------------------------------------
   bstap_pkg::bstap_state_e st_r, st_nxt;
   always_comb begin
      unique case (st_r)
         bstap_pkg::ST_RESET:  st_nxt = tms_s_r ? bstap_pkg::ST_RESET
                                              : bstap_pkg::ST_IDLE;
         bstap_pkg::ST_IDLE:   st_nxt = tms_s_r ? bstap_pkg::ST_SEL_DR
                                              : bstap_pkg::ST_IDLE;
         bstap_pkg::ST_SEL_DR: st_nxt = tms_s_r ? bstap_pkg::ST_SEL_IR
                                              : bstap_pkg::ST_CAP_DR;
         bstap_pkg::ST_CAP_DR: st_nxt = tms_s_r ? bstap_pkg::ST_EX1_DR
                                              : bstap_pkg::ST_SH_DR;
         bstap_pkg::ST_SH_DR:  st_nxt = tms_s_r ? bstap_pkg::ST_EX1_DR
                                              : bstap_pkg::ST_SH_DR;
         bstap_pkg::ST_EX1_DR: st_nxt = tms_s_r ? bstap_pkg::ST_UP_DR
                                              : bstap_pkg::ST_PA_DR;
         bstap_pkg::ST_PA_DR:  st_nxt = tms_s_r ? bstap_pkg::ST_EX2_DR
                                              : bstap_pkg::ST_PA_DR;
         bstap_pkg::ST_EX2_DR: st_nxt = tms_s_r ? bstap_pkg::ST_UP_DR
                                              : bstap_pkg::ST_SH_DR;
         bstap_pkg::ST_UP_DR:  st_nxt = tms_s_r ? bstap_pkg::ST_SEL_DR
                                              : bstap_pkg::ST_IDLE;
         bstap_pkg::ST_SEL_IR: st_nxt = tms_s_r ? bstap_pkg::ST_RESET
                                              : bstap_pkg::ST_CAP_IR;
         bstap_pkg::ST_CAP_IR: st_nxt = tms_s_r ? bstap_pkg::ST_EX1_IR
                                              : bstap_pkg::ST_SH_IR;
         bstap_pkg::ST_SH_IR:  st_nxt = tms_s_r ? bstap_pkg::ST_EX1_IR
                                              : bstap_pkg::ST_SH_IR;
         bstap_pkg::ST_EX1_IR: st_nxt = tms_s_r ? bstap_pkg::ST_UP_IR
                                              : bstap_pkg::ST_PA_IR;
         bstap_pkg::ST_PA_IR:  st_nxt = tms_s_r ? bstap_pkg::ST_EX2_IR
                                              : bstap_pkg::ST_PA_IR;
         bstap_pkg::ST_EX2_IR: st_nxt = tms_s_r ? bstap_pkg::ST_UP_IR
                                              : bstap_pkg::ST_SH_IR;
         bstap_pkg::ST_UP_IR:  st_nxt = tms_s_r ? bstap_pkg::ST_SEL_DR
                                              : bstap_pkg::ST_IDLE;
      endcase
   end
   // Five highs reach reset from any state via the select states
   always_ff @(posedge clk) begin
      if (rst)       st_r <= bstap_pkg::ST_RESET;
      else if (step) st_r <= st_nxt;
   end

   // ---------------------------------------------------------------------
   // Instruction decode
   // ---------------------------------------------------------------------
   logic [7:0] ir_sh_r;
   logic [7:0] ir_lat_r;
   wire  [6:0] opc = ir_lat_r[6:0];
   wire op_bnd = (opc == bstap_pkg::OP_EXTEST) || (opc == bstap_pkg::OP_SAMPLE)
              || (opc == bstap_pkg::OP_INTEST) || (opc == bstap_pkg::OP_READBN)
              || (opc == bstap_pkg::OP_READBT) || (opc == bstap_pkg::OP_CELLT);
   wire op_bcr = (opc == bstap_pkg::OP_SCANCN)
              || (opc == bstap_pkg::OP_SCANCT);
   wire op_test = (opc == bstap_pkg::OP_EXTEST) || (opc == bstap_pkg::OP_INTEST)
              || (opc == bstap_pkg::OP_HIGHZ) || (opc == bstap_pkg::OP_CLAMP)
              || (opc == bstap_pkg::OP_RUNT) || (opc == bstap_pkg::OP_READBT)
              || (opc == bstap_pkg::OP_TOPHIP) || (opc == bstap_pkg::OP_SCANCT);
   // Anything else falls to bypass; no parity check is made
   wire bstap_pkg::bstap_dr_e dr_sel = op_bnd ? bstap_pkg::DR_BOUND
                                     : op_bcr ? bstap_pkg::DR_BCTRL
                                     : bstap_pkg::DR_BYPASS;

   // ---------------------------------------------------------------------
   // Shift registers and shadow latches
   // ---------------------------------------------------------------------
   wire in_rst  = (st_r == bstap_pkg::ST_RESET);
   wire cap_ir  = step && (st_r == bstap_pkg::ST_CAP_IR);
   wire sh_ir   = step && (st_r == bstap_pkg::ST_SH_IR);
   wire cap_dr  = step && (st_r == bstap_pkg::ST_CAP_DR);
   wire sh_dr   = step && (st_r == bstap_pkg::ST_SH_DR);
   wire fall_ir = tck_fall && (st_r == bstap_pkg::ST_UP_IR);
   wire fall_dr = tck_fall && (st_r == bstap_pkg::ST_UP_DR);
   logic [1:0] bcr_sh_r;
   logic [1:0] bcr_lat_r;
   logic       byp_r;
   always_ff @(posedge clk) begin
      if (rst || in_rst) begin
         ir_sh_r  <= bstap_pkg::IR_RESET;
         ir_lat_r <= bstap_pkg::IR_RESET;
      end else begin
         if (cap_ir)     ir_sh_r  <= bstap_pkg::IR_STATUS;
         else if (sh_ir) ir_sh_r  <= {tdi_bit, ir_sh_r[7:1]};
         if (fall_ir)    ir_lat_r <= ir_sh_r;
      end
   end
   // Pause and exit states touch neither shift stage
   always_ff @(posedge clk) begin
      if (rst || in_rst) begin
         bcr_sh_r  <= bstap_pkg::BCR_RESET;
         bcr_lat_r <= bstap_pkg::BCR_RESET;
      end else begin
         if (sh_dr && dr_sel == bstap_pkg::DR_BCTRL)
            bcr_sh_r <= {tdi_bit, bcr_sh_r[1]};
         if (fall_dr && dr_sel == bstap_pkg::DR_BCTRL)
            bcr_lat_r <= bcr_sh_r;
      end
   end
   // Bypass has no shadow latch
   always_ff @(posedge clk) begin
      if (rst) byp_r <= 1'b0;
      else if (cap_dr && dr_sel == bstap_pkg::DR_BYPASS)
         byp_r <= bstap_pkg::BYP_CAP;
      else if (sh_dr && dr_sel == bstap_pkg::DR_BYPASS)
         byp_r <= tdi_bit;
   end

   // ---------------------------------------------------------------------
   // Serial output, driven on falling edges only
   // ---------------------------------------------------------------------
   wire in_ir_scan = (st_r == bstap_pkg::ST_CAP_IR) || (st_r == bstap_pkg::ST_SH_IR)
                  || (st_r == bstap_pkg::ST_EX1_IR) || (st_r == bstap_pkg::ST_PA_IR)
                  || (st_r == bstap_pkg::ST_EX2_IR);
   wire in_dr_scan = (st_r == bstap_pkg::ST_CAP_DR) || (st_r == bstap_pkg::ST_SH_DR)
                  || (st_r == bstap_pkg::ST_EX1_DR) || (st_r == bstap_pkg::ST_PA_DR)
                  || (st_r == bstap_pkg::ST_EX2_DR);
   wire dr_bit = (dr_sel == bstap_pkg::DR_BOUND) ? bsr_tdo
               : (dr_sel == bstap_pkg::DR_BCTRL) ? bcr_sh_r[0] : byp_r;
   // One register at a time: instruction path wins by construction
   wire scan_bit  = in_ir_scan ? ir_sh_r[0] : dr_bit;
   wire first_en  = tck_fall && !tdo_oe && (in_ir_scan || in_dr_scan);
   logic rst_seen_r;
   always_ff @(posedge clk) begin
      if (rst || in_rst)  rst_seen_r <= 1'b1;
      else if (first_en)  rst_seen_r <= 1'b0;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         tdo_o  <= 1'b0;
         tdo_oe <= 1'b0;
      end else if (tck_fall) begin
         tdo_oe <= in_ir_scan || in_dr_scan;
         if (first_en && (st_r == bstap_pkg::ST_CAP_IR || st_r == bstap_pkg::ST_CAP_DR))
            tdo_o <= rst_seen_r ? 1'b0 : tdo_o;
         else if (in_ir_scan || in_dr_scan)
            tdo_o <= scan_bit;
      end
   end

   // ---------------------------------------------------------------------
   // Strobes and decoded outputs, all registered
   // ---------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         bsr_strobe <= '0;
         bsr_sel    <= 1'b0;
         bsr_tdi    <= 1'b1;
         opcode     <= bstap_pkg::IR_RESET[6:0];
         test_mode  <= 1'b0;
         highz_mode <= 1'b0;
         bctrl_op   <= bstap_pkg::BCR_RESET;
         bctrl_run  <= 1'b0;
         tap_state  <= bstap_pkg::ST_RESET;
      end else begin
         bsr_sel            <= (dr_sel == bstap_pkg::DR_BOUND);
         bsr_strobe.capture <= cap_dr && op_bnd;
         bsr_strobe.shift   <= sh_dr && op_bnd;
         bsr_strobe.update  <= fall_dr && op_bnd;
         bsr_tdi            <= tdi_bit;
         opcode             <= opc;
         test_mode          <= op_test && !in_rst;
         highz_mode         <= (opc == bstap_pkg::OP_HIGHZ);
         bctrl_op           <= bcr_lat_r;
         // Tests run only while idle, after reset was left via idle
         bctrl_run          <= (opc == bstap_pkg::OP_RUNT)
                               && (st_r == bstap_pkg::ST_IDLE);
         tap_state          <= st_r;
      end
   end
endmodule : bstap_tap

`default_nettype wire

// [tb/bstap_master.sv]
/* Test bus master model for the scan port.
   Assumes clk is the bench clock; tck rests high between frames. */
`timescale 1ns/1ns
`default_nettype none
module bstap_master #(parameter int HALF = 4) (
   // Bench side
   input  wire logic clk,
   input  wire logic tdo_o,
   input  wire logic tdo_oe,
   // Test pins
   output logic      tck,
   output logic      tms,
   output logic      tdi
);
   // Released output reads as the pull-up level
   wire logic tdo_w = tdo_oe ? tdo_o : 1'b1;
   initial begin
      tck = 1'b1;
      tms = 1'b1;
      tdi = 1'b1;
   end
   // One test clock; pins move with the fall, held over the rise
   // Output is read late in the high half, once the synchronised fall
   // has had time to reach it
   task automatic step(input logic m, input logic d, output logic q);
      @(posedge clk);
      tck <= 1'b0;
      tms <= m;
      tdi <= d;
      repeat (HALF) @(posedge clk);
      tck <= 1'b1;
      repeat (HALF) @(posedge clk);
      q = tdo_w;
      tdi <= ~d;
   endtask : step
endmodule : bstap_master
`default_nettype wire

// [tb/bstap_tap_sva.sv]
/* Port checker for the scan controller, bound below.
   Assumes one clock clk with synchronous rst. */
`timescale 1ns/1ns
`default_nettype none
module bstap_tap_sva (
   // Clock and reset
   input wire logic                     clk,
   input wire logic                     rst,
   // Pins
   input wire logic                     tck_pin,
   input wire logic                     tms_pin,
   input wire logic                     tdo_o,
   input wire logic                     tdo_oe,
   // Controller outputs
   input wire bstap_pkg::bstap_strobe_s bsr_strobe,
   input wire logic [6:0]               opcode,
   input wire logic                     bctrl_run,
   input wire bstap_pkg::bstap_state_e  tap_state
);
   logic                    tck_r;
   logic [2:0]              hi_r;
   bstap_pkg::bstap_state_e st_r;
   // Raw pin edge runs ahead of the synchroniser, hence slack below
   always_ff @(posedge clk) begin
      tck_r <= tck_pin;
      st_r <= tap_state;
      if (rst)
         hi_r <= 3'h0;
      else if (tck_pin && !tck_r)
         hi_r <= tms_pin ? hi_r + {2'h0, hi_r != 3'h7} : 3'h0;
   end
   sequence s_left(bstap_pkg::bstap_state_e s);
      st_r == s && tap_state != s;
   endsequence
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // --------
   // Checks
   // --------
   property p_rst;
      $fell(rst) |-> tap_state == bstap_pkg::ST_RESET && opcode == 7'h7f
         && !tdo_oe;
   endproperty
   a_rst: assert property (p_rst) else $error("reset");
   property p_five;
      $rose(hi_r == 3'h5) |-> ##[1:16] tap_state == bstap_pkg::ST_RESET;
   endproperty
   a_five: assert property (p_five) else $error("five");
   property p_sel;
      (s_left(bstap_pkg::ST_SEL_DR) |-> tap_state inside
         {bstap_pkg::ST_CAP_DR, bstap_pkg::ST_SEL_IR}) and
      (s_left(bstap_pkg::ST_SEL_IR) |-> tap_state inside
         {bstap_pkg::ST_CAP_IR, bstap_pkg::ST_RESET});
   endproperty
   a_sel: assert property (p_sel) else $error("select");
   property p_cap;
      bsr_strobe.capture |-> tap_state == bstap_pkg::ST_CAP_DR ##1
         tap_state inside {bstap_pkg::ST_SH_DR, bstap_pkg::ST_EX1_DR};
   endproperty
   a_cap: assert property (p_cap) else $error("capture");
   property p_noshift;
      tap_state == bstap_pkg::ST_SH_DR && st_r != bstap_pkg::ST_SH_DR
         |-> !bsr_strobe.shift [*3];
   endproperty
   a_noshift: assert property (p_noshift) else $error("shift");
   property p_upd;
      bsr_strobe.update |-> tap_state == bstap_pkg::ST_UP_DR;
   endproperty
   a_upd: assert property (p_upd) else $error("update");
   property p_oe;
      (tap_state == bstap_pkg::ST_IDLE) [*2] |-> !tdo_oe;
   endproperty
   a_oe: assert property (p_oe) else $error("oe");
   property p_fall;
      $changed({tdo_o, tdo_oe}) |-> !$past(tck_pin, 5);
   endproperty
   a_fall: assert property (p_fall) else $error("tdo edge");
   property p_op;
      $changed(opcode) |-> ##[0:2] tap_state inside
         {bstap_pkg::ST_UP_IR, bstap_pkg::ST_RESET};
   endproperty
   a_op: assert property (p_op) else $error("opcode");
   property p_run;
      ((tap_state != bstap_pkg::ST_IDLE) [*2] |-> !bctrl_run) and
      (bctrl_run |-> opcode == bstap_pkg::OP_RUNT);
   endproperty
   a_run: assert property (p_run) else $error("run");
endmodule : bstap_tap_sva
bind bstap_tap bstap_tap_sva u_sva (
   .clk(clk), .rst(rst), .tck_pin(tck_pin), .tms_pin(tms_pin),
   .tdo_o(tdo_o), .tdo_oe(tdo_oe), .bsr_strobe(bsr_strobe),
   .opcode(opcode), .bctrl_run(bctrl_run), .tap_state(tap_state)
);
`default_nettype wire

// [tb/bstap_tap_tb.sv]
/* Testbench for the scan controller: scans through the master model.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ns
`default_nettype none
module bstap_tap_tb;
   logic                    clk = 1'b0;
   logic                    rst = 1'b1;
   logic                    bsr_tdo = 1'b0;
   logic                    tck, tms, tdi, tdo_o, tdo_oe, lead;
   logic                    bctrl_run, test_mode, highz_mode;
   logic [6:0]              opcode;
   logic [1:0]              bctrl_op, bcr;
   logic [7:0]              r, op;
   logic [31:0]             seed = 32'h0001_5872;
   bstap_pkg::bstap_state_e tap_state;
   int                      fails = 0;
   int                      n_tests = 0;
   always #20 clk = ~clk;
   always @(posedge clk) bsr_tdo <= seed[3];
   bstap_tap dut (
      .clk(clk), .rst(rst), .tck_pin(tck), .tms_pin(tms), .tdi_pin(tdi),
      .tdo_o(tdo_o), .tdo_oe(tdo_oe), .bsr_tdo(bsr_tdo), .bsr_strobe(),
      .bsr_sel(), .bsr_tdi(), .opcode(opcode), .test_mode(test_mode),
      .highz_mode(highz_mode), .bctrl_op(bctrl_op), .bctrl_run(bctrl_run),
      .tap_state(tap_state)
   );
   bstap_master #(.HALF(4)) m (
      .clk(clk), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
      .tdi(tdi)
   );
   // --------
   // Helpers
   // --------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   function automatic logic f_test(input logic [6:0] o);
      return o inside {7'h00, 7'h03, 7'h07, 7'h09, 7'h0b, 7'h0d, 7'h0f};
   endfunction : f_test
   function automatic logic f_byp(input logic [6:0] o);
      return !(o inside {7'h00, 7'h02, 7'h03, 7'h0a, 7'h0b, 7'h0c,
                         7'h0e, 7'h0f});
   endfunction : f_byp
   task automatic chk(input string w, input logic [7:0] e,
                      input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", w, e, g);
      end
   endtask : chk
   // Scan from idle; optional pause after the first bit
   task automatic scan(input logic ir, input int n, input int len,
                       input logic pz, input logic [7:0] v);
      logic q;
      r = 8'h0;
      m.step(1'b1, 1'b1, q);
      if (ir)
         m.step(1'b1, 1'b1, q);
      m.step(1'b0, 1'b1, q);
      m.step(1'b0, 1'b1, q);
      chk("lead", {7'h0, lead}, {7'h0, q});
      for (int i = 0; i < n; i++) begin
         m.step(i == n - 1 || (pz && i == 0), v[i], q);
         r[i] = q;
         if (pz && i == 0)
            for (int k = 0; k < 4; k++)
               m.step(k == 2, 1'b1, q);
      end
      m.step(1'b1, 1'b1, q);
      m.step(1'b0, 1'b1, q);
      // Let the last rise pass the synchroniser before looking
      repeat (8) @(posedge clk);
      lead = v[n - len];
      chk("oe", 8'h0, {7'h0, tdo_oe});
   endtask : scan
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      $display("CHECK FAILED watchdog expected end seen hang");
      results();
   end
   initial begin
      lead = 1'b0;
      bcr = 2'h2;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("op", 8'h7f, {1'b0, opcode});
      chk("bcr", 8'h02, {6'h0, bctrl_op});
      m.step(1'b0, 1'b1, r[0]);
      $display("test reset done");
      for (int i = 0; i < 24; i++) begin
         seed = xs(seed);
         op = i < 16 ? {seed[7], 3'h0, i[3:0]} : seed[7:0];
         scan(1'b1, 8, 8, i[0], op);
         chk("cap ir", 8'h81, r);
         chk("opcode", {1'b0, op[6:0]}, {1'b0, opcode});
         chk("run", {7'h0, op[6:0] == 7'h09}, {7'h0, bctrl_run});
         chk("hiz", {7'h0, op[6:0] == 7'h06}, {7'h0, highz_mode});
         if (op[6:0] != 7'h06)
            chk("mode", {7'h0, f_test(op[6:0])}, {7'h0, test_mode});
         if (f_byp(op[6:0])) begin
            scan(1'b0, 2, 1, i[1], seed[15:8]);
            chk("byp", {6'h0, seed[8], 1'b0}, r);
         end else if (op[3:1] == 3'h7) begin
            scan(1'b0, 2, 2, i[1], seed[15:8]);
            chk("bcr cap", {6'h0, bcr}, r);
            bcr = seed[9:8];
            chk("bcr", {6'h0, bcr}, {6'h0, bctrl_op});
         end
      end
      $display("test instructions done");
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         for (int k = 0; k < seed[3:0]; k++)
            m.step(seed[k + 4], seed[k + 16], r[0]);
         for (int k = 0; k < 5; k++)
            m.step(1'b1, 1'b1, r[0]);
         repeat (8) @(posedge clk);
         chk("tlr", 8'h00, {4'h0, tap_state});
         chk("op", 8'h7f, {1'b0, opcode});
         chk("bcr", 8'h02, {6'h0, bctrl_op});
         chk("mode", 8'h00, {7'h0, test_mode});
         m.step(1'b0, 1'b1, r[0]);
      end
      lead = 1'b0;
      scan(1'b1, 8, 8, 1'b0, 8'h81);
      chk("cap ir", 8'h81, r);
      $display("test reset walk done");
      results();
   end
endmodule : bstap_tap_tb
`default_nettype wire
